// File: test/lbm_master_tb.sv
// Self-checking bench for the local bus master cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module lbm_master_tb;
  typedef struct {logic [31:0] conf; logic [31:0] cmd; logic [3:0] stall;} lbm_row_t;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, lclk, ale, hbe, cs, rd, wr, oe, rdy, hold, hack, rereq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] la, din, dout;
  logic [3:0] stall;
  logic e;
  int fail_count, checks_done, cyc, last_end, last_gap;
  lbm_row_t rows [7] = '{
    '{32'h0000_0000, 32'h0000_1234, 4'h0}, '{32'h0000_0300, 32'h8abc_0042, 4'h0},
    '{32'h0000_0101, 32'h4000_00f0, 4'h0}, '{32'h0000_5000, 32'h0000_0777, 4'h0},
    '{32'h0000_4000, 32'h9001_0300, 4'h0}, '{32'h0000_0000, 32'h0000_0055, 4'h3},
    '{32'h0000_2000, 32'h0000_0066, 4'h3}};
  lbm_master dut (.REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LOCAL_CLOCK_OUT_O(lclk), .ADDR_LATCH_STROBE_O(ale), .LOCAL_ADDRESS_LINES_O(la),
    .HIGH_BYTE_ENABLE_O(hbe), .CHIP_SELECT_OUT_O(cs), .READ_STROBE_O(rd), .WRITE_STROBE_O(wr),
    .LOCAL_DATA_BUS_I(din), .LOCAL_DATA_BUS_O(dout), .LOCAL_DATA_BUS_OE_O(oe),
    .LOCAL_WAIT_READY_I(rdy), .HOLD_REQUEST_IN_I(hold), .HOLD_ACK_OUT_O(hack), .BUS_REREQUEST_OUT_O(rereq));
  lbm_periph per (.clk_i(clk), .rd_i(rd), .wr_i(wr), .addr_i(la), .stall_i(stall), .data_o(din), .rdy_o(rdy));
  ////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic poll();
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h008, 32'h0);
      n++;
    end while (d[31] !== 1'b0 && n < 200);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // One command with its timing measured at the pins
  task automatic run(input lbm_row_t r);
    int t, w, lead, aw, n, hi;
    t = r.conf[7:0] + 1;
    stall <= r.stall;
    apb(1'b1, 12'h000, r.conf);
    apb(1'b1, 12'h004, r.cmd);
    n = 0;
    while (cs !== 1'b1 && ale !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk(cyc - last_end >= last_gap, 1);
    lead = 0;
    aw = 0;
    while (rd !== 1'b1 && wr !== 1'b1 && lead < 500) begin
      if (ale === 1'b1) begin
        aw++;
        chk({oe, dout}, {1'b0, r.cmd[15:0]});
      end
      lead++;
      @(negedge clk);
    end
    if (r.conf[14]) chk(aw, r.conf[12] ? 2 * t : t);
    chk(lead, r.conf[14] ? 2 * t : t);
    chk({hbe, la}, {r.cmd[30], r.cmd[15:0]});
    w = 0;
    hi = 0;
    while ((rd === 1'b1 || wr === 1'b1) && w < 500) begin
      hi += int'(lclk === 1'b1);
      w++;
      @(negedge clk);
    end
    // Ready rows run at divider 0, so the stretch counts in system clocks
    if (r.conf[13]) chk(w, 2 + ((r.stall > r.conf[11:8]) ? r.stall : r.conf[11:8]));
    else chk(w, (2 + r.conf[11:8]) * t);
    chk(hi, (w / t) * (r.conf[7:1] + 1));
    last_end = cyc;
    last_gap = (r.cmd[31] ? 5 : 2) * t;
    if (r.cmd[31]) begin
      chk({oe, dout}, {1'b0, r.cmd[31:16]});
      @(negedge clk);
      chk(oe, 1);
    end
    // A command inside the closing gap must be refused
    apb(1'b1, 12'h004, r.cmd);
    chk(e, 1);
    poll();
    apb(1'b0, 12'h00c, 32'h0);
    if (!r.cmd[31]) chk(d[15:0], r.cmd[15:0] ^ 16'h5a5a);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock and cycle ceiling
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Reset, table of ordinary cycles, then hold and refusal cases
  initial begin
    {rstn, psel, pen, pwr, hold} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    stall = 4'h0;
    repeat (12) @(posedge clk);
    chk({oe, rd, wr, cs}, 4'h8);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(d, 32'h0000_0000);
    chk(e, 0);
    apb(1'b0, 12'h010, 32'h0);
    chk(d, 32'h0000_0000);
    chk(e, 1);
    foreach (rows[i]) run(rows[i]);
    hold <= 1'b1;
    repeat (4) @(posedge clk);
    chk(hack, 1);
    apb(1'b1, 12'h004, 32'h0000_0011);
    apb(1'b1, 12'h004, 32'h0000_0022);
    chk(e, 1);
    repeat (2) @(posedge clk);
    chk({rereq, rd, cs}, 3'h4);
    hold <= 1'b0;
    poll();
    chk({d[31], rereq, hack}, 3'h0);
    // Hold raised mid-cycle: grant only after the cycle ends
    apb(1'b1, 12'h004, 32'h0000_0033);
    while (cs !== 1'b1) @(posedge clk);
    hold <= 1'b1;
    while (cs === 1'b1) begin
      chk(hack, 0);
      @(posedge clk);
    end
    poll();
    repeat (3) @(posedge clk);
    chk(hack, 1);
    hold <= 1'b0;
    repeat (2) @(posedge clk);
    chk(hack, 0);
    give_verdict();
  end
endmodule
`default_nettype wire

// File: test/lbm_periph.sv
// Local peripheral model: read data source and ready stretcher
`timescale 1ns/100ps
`default_nettype none
module lbm_periph (
  // Clock
  input wire logic clk_i,
  // Local bus
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] stall_i,
  output logic [15:0] data_o,
  output logic rdy_o
);
  logic [15:0] dat_ff = 16'h0000;
  logic [3:0] cnt_ff = 4'h0;
  logic was_ff = 1'b0;
  // Wait count loads at strobe rise; data only while read strobe, else toggling
  always @(posedge clk_i) begin
    was_ff <= rd_i | wr_i;
    cnt_ff <= ((rd_i | wr_i) && !was_ff) ? stall_i : (cnt_ff != 4'h0 ? cnt_ff - 4'h1 : 4'h0);
    dat_ff <= rd_i ? (addr_i ^ 16'h5a5a) : ~dat_ff;
  end
  assign data_o = dat_ff;
  assign rdy_o = (cnt_ff == 4'h0);
endmodule
`default_nettype wire

// File: verilog/lbm_defines.svh
// Timing counts, field widths and configuration fields of the local bus master
`ifndef LBM_DEFINES_SVH
`define LBM_DEFINES_SVH
`define LBM_APB_CONF 12'h000
`define LBM_APB_CMD 12'h004
`define LBM_APB_STAT 12'h008
`define LBM_APB_RDATA 12'h00c
`define LBM_DIV_LSB 0
`define LBM_DIV_MSB 7
`define LBM_WAIT_LSB 8
`define LBM_WAIT_MSB 11
`define LBM_EXT_BIT 12
`define LBM_READY_INPUT_ENABLE_BIT 13
`define LBM_MUX_BIT 14
`define LBM_CONF_RST 32'h0000_0000
`define LBM_STROBE_BASE 5'h02
`define LBM_GAP_RD 5'h02
`define LBM_GAP_WR 5'h05
`define LBM_ALE_NORM 2'h1
`define LBM_ALE_EXT 2'h2
`define LBM_ADDR_PHASE 5'h02
`define LBM_HOLD_CLKS 2'h1
`endif

// File: verilog/lbm_master.sv
// Local bus master port: cycle sequencing behind an APB register slave
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "lbm_defines.svh"
module lbm_master (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Local bus
  output logic LOCAL_CLOCK_OUT_O,
  output logic ADDR_LATCH_STROBE_O,
  output logic [15:0] LOCAL_ADDRESS_LINES_O,
  output logic HIGH_BYTE_ENABLE_O,
  output logic CHIP_SELECT_OUT_O,
  output logic READ_STROBE_O,
  output logic WRITE_STROBE_O,
  input wire logic [15:0] LOCAL_DATA_BUS_I,
  output logic [15:0] LOCAL_DATA_BUS_O,
  output logic LOCAL_DATA_BUS_OE_O,
  input wire logic LOCAL_WAIT_READY_I,
  // Arbitration
  input wire logic HOLD_REQUEST_IN_I,
  output logic HOLD_ACK_OUT_O,
  output logic BUS_REREQUEST_OUT_O
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] local_bus_config_ff;
  lbm_pkg::lbm_req_t req_ff;
  logic pend_ff;
  logic [15:0] rdata_ff;
  lbm_pkg::lbm_state_t st_ff, nxt_st;
  logic [7:0] div_ff;
  logic tick_ff;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [1:0] hold_ff;
  logic mux_cyc_ff;
  logic [1:0] ale_cnt_ff;

  // Configuration fields
  wire [7:0] div_factor = local_bus_config_ff[`LBM_DIV_MSB:`LBM_DIV_LSB];
  wire [3:0] master_wait_count = local_bus_config_ff[`LBM_WAIT_MSB:`LBM_WAIT_LSB];
  wire latch_pulse_extend = local_bus_config_ff[`LBM_EXT_BIT];
  wire ready_input_enable = local_bus_config_ff[`LBM_READY_INPUT_ENABLE_BIT];
  wire mux_mode = local_bus_config_ff[`LBM_MUX_BIT];

  // APB decode
  wire apb_acc = PSEL_I & PENABLE_I;
  wire apb_wr = apb_acc & PWRITE_I;
  wire hit_conf = PADDR_I == `LBM_APB_CONF;
  wire hit_cmd = PADDR_I == `LBM_APB_CMD;
  wire hit_stat = PADDR_I == `LBM_APB_STAT;
  wire hit_rd = PADDR_I == `LBM_APB_RDATA;
  wire hit_any = hit_conf | hit_cmd | hit_stat | hit_rd;
  wire cmd_take = apb_wr & hit_cmd & ~pend_ff;
  wire [31:0] rd_mux = hit_conf ? local_bus_config_ff :
                       hit_stat ? {25'h0, st_ff} | {pend_ff, 31'h00000000} :
                       hit_rd ? {16'h0000, rdata_ff} : 32'h0000_0000;

  // Strobe may end: base+waits done and ready not stretching
  wire rdy_wait = ready_input_enable & ~LOCAL_WAIT_READY_I;
  wire strobe_done = (cnt_ff == 5'h00) & ~rdy_wait;
  wire idle_ok = st_ff == lbm_pkg::LBM_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait, error on unmapped or busy command
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      local_bus_config_ff <= `LBM_CONF_RST;
      PRDATA_O <= 32'h0000_0000;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & (~hit_any | (PWRITE_I & hit_cmd & pend_ff));
      PRDATA_O <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_mux : 32'h0000_0000;
      if (apb_wr & hit_conf & PREADY_O) local_bus_config_ff <= PWDATA_I;
    end
  end

  // Command word: address low half, write data high half
  // An access flagged as refused at setup never loads, even if the gap ends meanwhile
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      req_ff <= '0;
      pend_ff <= 1'b0;
    end else begin
      if (cmd_take & PREADY_O & ~PSLVERR_O) begin
        req_ff <= {PWDATA_I[15:0], PWDATA_I[31:16], PWDATA_I[31], PWDATA_I[30]};
        pend_ff <= 1'b1;
      end else if (st_ff == lbm_pkg::LBM_GAP && nxt_st != lbm_pkg::LBM_GAP) begin
        pend_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Local clock divider: tick every div_factor+1 system clocks
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      div_ff <= 8'h00;
      tick_ff <= 1'b0;
      LOCAL_CLOCK_OUT_O <= 1'b0;
    end else begin
      // Wrap at once if a smaller factor is written mid-count
      tick_ff <= div_ff >= div_factor;
      div_ff <= (div_ff >= div_factor) ? 8'h00 : div_ff + 8'h01;
      LOCAL_CLOCK_OUT_O <= div_ff < {1'b0, div_factor[7:1]} + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle state machine, advancing on local ticks except out of data hold and into or out of hold
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      lbm_pkg::LBM_IDLE: begin
        if (hold_ff == `LBM_HOLD_CLKS) nxt_st = lbm_pkg::LBM_HELD;
        else if (pend_ff & tick_ff & ~HOLD_REQUEST_IN_I) begin
          nxt_st = mux_mode ? lbm_pkg::LBM_ADDR : lbm_pkg::LBM_SETUP;
          nxt_cnt = `LBM_ADDR_PHASE - 5'h01;
        end
      end
      lbm_pkg::LBM_ADDR: if (tick_ff) begin
        if (cnt_ff == 5'h00) begin
          nxt_st = lbm_pkg::LBM_STRB;
          nxt_cnt = `LBM_STROBE_BASE + {1'b0, master_wait_count} - 5'h01;
        end else nxt_cnt = cnt_ff - 5'h01;
      end
      lbm_pkg::LBM_SETUP: if (tick_ff) begin
        nxt_st = lbm_pkg::LBM_STRB;
        nxt_cnt = `LBM_STROBE_BASE + {1'b0, master_wait_count} - 5'h01;
      end
      lbm_pkg::LBM_STRB: if (tick_ff) begin
        if (strobe_done) begin
          nxt_st = req_ff.write ? lbm_pkg::LBM_DHOLD : lbm_pkg::LBM_GAP;
          nxt_cnt = (req_ff.write ? `LBM_GAP_WR : `LBM_GAP_RD) - 5'h01;
        end else if (cnt_ff != 5'h00) nxt_cnt = cnt_ff - 5'h01;
      end
      lbm_pkg::LBM_DHOLD: nxt_st = lbm_pkg::LBM_GAP;
      lbm_pkg::LBM_GAP: if (tick_ff) begin
        if (cnt_ff == 5'h00) nxt_st = lbm_pkg::LBM_IDLE;
        else nxt_cnt = cnt_ff - 5'h01;
      end
      lbm_pkg::LBM_HELD: if (!HOLD_REQUEST_IN_I) nxt_st = lbm_pkg::LBM_IDLE;
      default: nxt_st = lbm_pkg::LBM_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      st_ff <= lbm_pkg::LBM_IDLE;
      cnt_ff <= 5'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // Hold qualification: grant only from idle
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) hold_ff <= 2'h0;
    else if (HOLD_REQUEST_IN_I & idle_ok) hold_ff <= (hold_ff == `LBM_HOLD_CLKS) ? hold_ff : hold_ff + 2'h1;
    else hold_ff <= 2'h0;
  end

  // Latch strobe length counter
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) ale_cnt_ff <= 2'h0;
    else if (st_ff == lbm_pkg::LBM_IDLE && nxt_st == lbm_pkg::LBM_ADDR)
      ale_cnt_ff <= latch_pulse_extend ? `LBM_ALE_EXT : `LBM_ALE_NORM;
    else if (tick_ff && ale_cnt_ff != 2'h0) ale_cnt_ff <= ale_cnt_ff - 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs, all registered
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      ADDR_LATCH_STROBE_O <= 1'b0;
      LOCAL_ADDRESS_LINES_O <= 16'h0000;
      HIGH_BYTE_ENABLE_O <= 1'b0;
      CHIP_SELECT_OUT_O <= 1'b0;
      READ_STROBE_O <= 1'b0;
      WRITE_STROBE_O <= 1'b0;
      LOCAL_DATA_BUS_O <= 16'h0000;
      LOCAL_DATA_BUS_OE_O <= 1'b1;
      HOLD_ACK_OUT_O <= 1'b0;
      BUS_REREQUEST_OUT_O <= 1'b0;
      rdata_ff <= 16'h0000;
      mux_cyc_ff <= 1'b0;
    end else begin
      mux_cyc_ff <= (nxt_st == lbm_pkg::LBM_ADDR);
      ADDR_LATCH_STROBE_O <= (nxt_st == lbm_pkg::LBM_ADDR) &
        ((st_ff == lbm_pkg::LBM_IDLE) | (ale_cnt_ff > 2'h1) | ((ale_cnt_ff == 2'h1) & ~tick_ff));
      LOCAL_ADDRESS_LINES_O <= req_ff.addr;
      HIGH_BYTE_ENABLE_O <= req_ff.hi_byte;
      CHIP_SELECT_OUT_O <= nxt_st inside {lbm_pkg::LBM_ADDR, lbm_pkg::LBM_SETUP, lbm_pkg::LBM_STRB};
      READ_STROBE_O <= (nxt_st == lbm_pkg::LBM_STRB) & ~req_ff.write;
      WRITE_STROBE_O <= (nxt_st == lbm_pkg::LBM_STRB) & req_ff.write;
      // Address on shared lines in mux address phase, else write data
      LOCAL_DATA_BUS_O <= (nxt_st == lbm_pkg::LBM_ADDR) ? req_ff.addr : req_ff.data;
      LOCAL_DATA_BUS_OE_O <= ~((nxt_st == lbm_pkg::LBM_ADDR) |
        (req_ff.write & (nxt_st inside {lbm_pkg::LBM_SETUP, lbm_pkg::LBM_STRB, lbm_pkg::LBM_DHOLD})));
      HOLD_ACK_OUT_O <= nxt_st == lbm_pkg::LBM_HELD;
      BUS_REREQUEST_OUT_O <= (nxt_st == lbm_pkg::LBM_HELD) & pend_ff;
      if (st_ff == lbm_pkg::LBM_STRB && tick_ff && strobe_done && !req_ff.write) rdata_ff <= LOCAL_DATA_BUS_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_strobe_end;
    $fell(WRITE_STROBE_O);
  endsequence
  chk_wr_data_hold: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    s_strobe_end |-> !LOCAL_DATA_BUS_OE_O ##1 LOCAL_DATA_BUS_OE_O) else $error("write data hold wrong");
  chk_rdy_ignored: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (st_ff == lbm_pkg::LBM_STRB && !ready_input_enable && cnt_ff == 5'h00 && tick_ff)
    |=> st_ff != lbm_pkg::LBM_STRB) else $error("ready not ignored");
  chk_rdy_stretch: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (st_ff == lbm_pkg::LBM_STRB && rdy_wait && tick_ff)
    |=> st_ff == lbm_pkg::LBM_STRB) else $error("ready stretch lost");
  chk_strb_base: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (st_ff != lbm_pkg::LBM_STRB && nxt_st == lbm_pkg::LBM_STRB)
    |=> cnt_ff == `LBM_STROBE_BASE + {1'b0, master_wait_count} - 5'h01) else $error("strobe length wrong");
  chk_gap_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(st_ff == lbm_pkg::LBM_GAP) && req_ff.write |-> cnt_ff == `LBM_GAP_WR - 5'h01) else $error("write gap wrong");
  chk_gap_read: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(st_ff == lbm_pkg::LBM_GAP) && !req_ff.write |-> cnt_ff == `LBM_GAP_RD - 5'h01) else $error("read gap wrong");
  chk_demux_setup: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    (st_ff == lbm_pkg::LBM_SETUP && tick_ff) |=> st_ff == lbm_pkg::LBM_STRB) else $error("demux strobe late");
  chk_hold_idle: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(HOLD_ACK_OUT_O) |-> !READ_STROBE_O && !WRITE_STROBE_O && !CHIP_SELECT_OUT_O) else $error("hold during cycle");
endmodule
`default_nettype wire

// File: verilog/lbm_pkg.sv
// Types shared by the local bus master
package lbm_pkg;
  typedef enum logic [6:0] {
    LBM_IDLE = 7'h01, LBM_ADDR = 7'h02, LBM_SETUP = 7'h04, LBM_STRB = 7'h08,
    LBM_DHOLD = 7'h10, LBM_GAP = 7'h20, LBM_HELD = 7'h40
  } lbm_state_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic write;
    logic hi_byte;
  } lbm_req_t;
endpackage
